/* serirq_host.sv */
// Host-side serial interrupt master model on a wired-AND line
`timescale 1ns/1ps

module serirq_host (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] start_len,
    input wire logic [3:0] stop_len,
    input wire logic [7:0] n_clk,
    input wire logic dev_o,
    input wire logic dev_oe,
    output logic line,
    output logic busy,
    output logic [97:0] oe_seen,
    output logic [97:0] o_seen
);
    logic host_low = 1'b0;
    int k;
    // ========================================================================
    // Open-drain line with pull-up; host high clock is the released level
    assign line = !(host_low || (dev_oe && !dev_o));
    // ========================================================================
    // One serial interrupt cycle per request or device start
    initial
    begin
        busy = 1'b0;
        forever
        begin
            @(posedge clk);
            #2;
            if (go || !line)
            begin
                busy = 1'b1;
                k = line ? start_len : start_len - 1;
                @(posedge clk);
                #1 host_low = 1'b1;
                repeat (k) @(posedge clk);
                #1 host_low = 1'b0;
                for (int c = 0; c < n_clk; c++)
                begin
                    #4;
                    if (c < 98)
                    begin
                        oe_seen[c] = dev_oe;
                        o_seen[c] = dev_o;
                    end
                    @(posedge clk);
                end
                #1 host_low = 1'b1;
                repeat (stop_len) @(posedge clk);
                #1 host_low = 1'b0;
                #1 busy = 1'b0;
            end
        end
    end
endmodule

/* serirq_pkg.sv */
// Shared types and constants for the serial interrupt slave frame engine
package serirq_pkg;

    // ========================================================================
    // Frame engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DATA = 3'h2,
        ST_STOP = 3'h4
    } state_t;

    // ========================================================================
    // Phases of one IRQ/Data frame
    typedef enum logic [1:0] {
        PH_SAMPLE = 2'h0,
        PH_RECOV  = 2'h1,
        PH_TURN   = 2'h2
    } phase_t;

    // ========================================================================
    // Line drive carrier
    typedef struct packed {
        logic o;
        logic oe;
    } drive_t;

    localparam drive_t DRV_OFF = 2'h0;
    localparam drive_t DRV_LOW = 2'h1;
    localparam drive_t DRV_HIGH = 2'h3;

    // ========================================================================
    // Frame counts and pulse widths
    localparam int FRAME_COUNT = 32;
    localparam logic [5:0] SLOT_LEAD = 6'h3f;
    localparam logic [5:0] SLOT_LAST = 6'h1f;
    localparam logic [3:0] LOW_MAX = 4'hf;
    localparam logic [3:0] LOW_NONE = 4'h0;
    localparam logic [3:0] START_MIN_LOW = 4'h4;
    localparam logic [3:0] STOP_QUIET_LOW = 4'h2;
    localparam logic [3:0] STOP_CONT_LOW = 4'h3;

    // ========================================================================
    // Reset values
    localparam logic QUIET_RESET = 1'h0;

endpackage

/* serirq_slave.sv */
// Serial interrupt slave: start detection, frame slots and stop mode decode
// Behaviour
// - Quiet mode: device may pull first start clock low; host holds rest.
// - Frame counting starts from the rising edge ending the start pulse.
// - Each IRQ/Data frame is three clocks: sample, recovery, turn-around.
// - Sample clock: pull low if that request is active, else leave undriven.
// - Recovery clock after a low sample: drive the line high.
// - Turn-around clock: release the line.
// - Slot driving starts at frame 1; all changes on rising clock edges.
// - Frames 1-16 carry IRQ0-15, frame 3 carries SMI; sample at 3n-1.
// - Frames 17-21 carry IOCHCK and INTA-D; frames 22-32 unassigned, last 95.
// - Stop low two clocks selects quiet, three selects continuous mode.
// - Any number of idle clocks after the stop frame is tolerated.
// - New start pulse accepted right after stop or after any idle gap.
// - Device start drive in quiet mode lasts exactly one clock.
// - In continuous mode only the host starts a frame.
// - Reset leaves the device in continuous mode.
`timescale 1ns/1ps

module serirq_slave (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [31:0] IRQ_REQ,
    input wire logic SERIRQ_I,
    output logic SERIRQ_O,
    output logic SERIRQ_OE,
    output logic QUIET_MODE
);

    // ========================================================================
    // State
    serirq_pkg::state_t state_q;
    serirq_pkg::state_t state_d;
    serirq_pkg::phase_t phase_q;
    serirq_pkg::phase_t phase_d;
    serirq_pkg::drive_t drv_q;
    serirq_pkg::drive_t drv_d;
    logic [5:0] slot_q;
    logic [5:0] slot_d;
    logic [3:0] low_q;
    logic [3:0] low_d;
    logic quiet_q;
    logic quiet_d;

    // ========================================================================
    // Decode
    wire line_low = ~SERIRQ_I;
    wire in_idle = (state_q == serirq_pkg::ST_IDLE);
    wire in_data = (state_q == serirq_pkg::ST_DATA);
    wire [3:0] low_inc = (low_q == serirq_pkg::LOW_MAX) ? low_q : 4'(low_q + 4'h1);
    wire start_seen = in_idle & SERIRQ_I & (low_q >= serirq_pkg::START_MIN_LOW);
    wire quiet_go = in_idle & quiet_q & (|IRQ_REQ) & SERIRQ_I
                    & (low_q == serirq_pkg::LOW_NONE) & ~drv_q.oe;
    wire phase_wrap = (phase_q == serirq_pkg::PH_TURN);
    wire [1:0] phase_nx = phase_wrap ? serirq_pkg::PH_SAMPLE : 2'(phase_q + 2'h1);
    wire [5:0] slot_nx = phase_wrap ? 6'(slot_q + 6'h1) : slot_q;
    wire last_done = in_data & phase_wrap & (slot_q == serirq_pkg::SLOT_LAST);
    wire stop_early = in_data & (phase_q == serirq_pkg::PH_RECOV) & ~drv_q.oe & line_low;
    wire drove_sample = drv_q.oe & ~drv_q.o & (phase_q == serirq_pkg::PH_SAMPLE);
    wire req_bit = IRQ_REQ[slot_nx[4:0]];
    wire stop_end = (state_q == serirq_pkg::ST_STOP) & SERIRQ_I
                    & (low_q != serirq_pkg::LOW_NONE);

    // ========================================================================
    // Frame engine
    always_comb
    begin
        state_d = state_q;
        phase_d = phase_q;
        slot_d = slot_q;
        low_d = low_q;
        drv_d = serirq_pkg::DRV_OFF;
        quiet_d = quiet_q;
        unique case (state_q)
            serirq_pkg::ST_IDLE:
            begin
                low_d = line_low ? low_inc : serirq_pkg::LOW_NONE;
                if (start_seen)
                begin
                    state_d = serirq_pkg::ST_DATA;
                    phase_d = serirq_pkg::PH_TURN;
                    slot_d = serirq_pkg::SLOT_LEAD;
                end
                else if (quiet_go)
                begin
                    drv_d = serirq_pkg::DRV_LOW;
                end
            end
            serirq_pkg::ST_DATA:
            begin
                phase_d = serirq_pkg::phase_t'(phase_nx);
                slot_d = slot_nx;
                if (phase_nx == serirq_pkg::PH_SAMPLE && req_bit)
                begin
                    drv_d = serirq_pkg::DRV_LOW;
                end
                else if (phase_nx == serirq_pkg::PH_RECOV && drove_sample)
                begin
                    drv_d = serirq_pkg::DRV_HIGH;
                end
                if (last_done)
                begin
                    state_d = serirq_pkg::ST_STOP;
                    low_d = serirq_pkg::LOW_NONE;
                    drv_d = serirq_pkg::DRV_OFF;
                end
                else if (stop_early)
                begin
                    state_d = serirq_pkg::ST_STOP;
                    low_d = serirq_pkg::STOP_QUIET_LOW;
                    drv_d = serirq_pkg::DRV_OFF;
                end
            end
            serirq_pkg::ST_STOP:
            begin
                if (line_low)
                begin
                    low_d = low_inc;
                end
                else if (stop_end)
                begin
                    state_d = serirq_pkg::ST_IDLE;
                    low_d = serirq_pkg::LOW_NONE;
                    if (low_q == serirq_pkg::STOP_QUIET_LOW)
                    begin
                        quiet_d = 1'h1;
                    end
                    else if (low_q == serirq_pkg::STOP_CONT_LOW)
                    begin
                        quiet_d = 1'h0;
                    end
                end
            end
            default:
            begin
                state_d = serirq_pkg::ST_IDLE;
                low_d = serirq_pkg::LOW_NONE;
            end
        endcase
    end

    // ========================================================================
    // Registers
    always_ff @(posedge REF_CLK)
    begin
        if (!RSTN)
        begin
            state_q <= serirq_pkg::ST_IDLE;
            phase_q <= serirq_pkg::PH_TURN;
            slot_q <= serirq_pkg::SLOT_LEAD;
            low_q <= serirq_pkg::LOW_NONE;
            drv_q <= serirq_pkg::DRV_OFF;
            quiet_q <= serirq_pkg::QUIET_RESET;
        end
        else
        begin
            state_q <= state_d;
            phase_q <= phase_d;
            slot_q <= slot_d;
            low_q <= low_d;
            drv_q <= drv_d;
            quiet_q <= quiet_d;
        end
    end

    assign SERIRQ_O = drv_q.o;
    assign SERIRQ_OE = drv_q.oe;
    assign QUIET_MODE = quiet_q;

    // ========================================================================
    // Checks
    AST_QUIET_ONE_CLOCK: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (in_idle && SERIRQ_OE) |=> !SERIRQ_OE)
        else $error("Quiet start drive longer than one clock");

    AST_CONT_NO_START: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (in_idle && !quiet_q) |=> !SERIRQ_OE)
        else $error("Start driven in continuous mode");

    AST_FRAME_PHASES: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (in_data && phase_q == serirq_pkg::PH_SAMPLE)
        |=> (phase_q == serirq_pkg::PH_RECOV) ##1 (phase_q == serirq_pkg::PH_TURN))
        else $error("Frame phase order broken");

    AST_SAMPLE_LOW: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (in_data && phase_q == serirq_pkg::PH_SAMPLE && SERIRQ_OE) |-> !SERIRQ_O)
        else $error("Sample clock driven high");

    AST_RECOVERY_HIGH: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (in_data && SERIRQ_OE && !SERIRQ_O && !stop_early && !last_done)
        |=> (SERIRQ_OE && SERIRQ_O))
        else $error("Recovery after low sample not driven high");

    AST_TURN_RELEASE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (in_data && phase_q == serirq_pkg::PH_TURN) |-> !SERIRQ_OE)
        else $error("Line driven in turn-around");

    AST_FIRST_SLOT: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        start_seen |=> ##1 (slot_q == 6'h00 && phase_q == serirq_pkg::PH_SAMPLE))
        else $error("First frame not two clocks after start edge");

    AST_LAST_FRAME: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        last_done |=> (state_q == serirq_pkg::ST_STOP && !SERIRQ_OE))
        else $error("No stop wait after frame 32");

    AST_STOP_QUIET: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (stop_end && low_q == serirq_pkg::STOP_QUIET_LOW) |=> QUIET_MODE)
        else $error("Two clock stop did not select quiet mode");

    AST_STOP_CONT: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (stop_end && low_q == serirq_pkg::STOP_CONT_LOW) |=> !QUIET_MODE)
        else $error("Three clock stop did not select continuous mode");

    AST_EARLY_STOP: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        stop_early |=> (state_q == serirq_pkg::ST_STOP && low_q == serirq_pkg::STOP_QUIET_LOW))
        else $error("Host stop in a recovery clock not taken");

    AST_SHORT_LOW_IGNORED: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (in_idle && SERIRQ_I && low_q < serirq_pkg::START_MIN_LOW) |=> in_idle)
        else $error("Start taken after fewer than four low clocks");

endmodule

/* tb_top.sv */
// Self-checking testbench for the serial interrupt slave
`timescale 1ns/1ps

module tb_top;
    logic REF_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [31:0] IRQ_REQ = 32'h0;
    logic go = 1'b0;
    logic [3:0] start_len = 4'h4;
    logic [3:0] stop_len = 4'h3;
    logic [7:0] n_clk = 8'h62;
    logic line, busy, SERIRQ_O, SERIRQ_OE, QUIET_MODE;
    logic [97:0] oe_seen, o_seen;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    // ========================================================================
    // Clock, run limit and instances
    always #5 REF_CLK = !REF_CLK;
    always @(posedge REF_CLK)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            stop_test();
        end
    end
    serirq_slave dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .IRQ_REQ(IRQ_REQ), .SERIRQ_I(line),
        .SERIRQ_O(SERIRQ_O), .SERIRQ_OE(SERIRQ_OE), .QUIET_MODE(QUIET_MODE));
    serirq_host host (.clk(REF_CLK), .go(go), .start_len(start_len), .stop_len(stop_len),
        .n_clk(n_clk),
        .dev_o(SERIRQ_O), .dev_oe(SERIRQ_OE), .line(line), .busy(busy),
        .oe_seen(oe_seen), .o_seen(o_seen));
    // ========================================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 300 && busy !== lvl; i++)
        begin
            @(posedge REF_CLK);
            #1;
        end
        check(32'(busy), 32'(lvl));
    endtask
    task automatic run_cycle(input logic [3:0] s, input logic [3:0] p);
        start_len = s;
        stop_len = p;
        go = 1'b1;
        @(posedge REF_CLK);
        #1;
        wait_busy(1'b1);
        go = 1'b0;
        wait_busy(1'b0);
    endtask
    task automatic check_frames(input logic [31:0] req, input int nf);
        int c;
        check(32'(oe_seen[1:0]), 32'h0);
        for (int n = 1; n <= nf; n++)
        begin
            c = 3 * n - 1;
            check(32'({oe_seen[c], o_seen[c], oe_seen[c+1], o_seen[c+1], oe_seen[c+2]}),
                req[n-1] ? 32'h16 : 32'h0);
        end
    endtask
    // ========================================================================
    // Scenarios
    task automatic test_reset();
        check(32'({QUIET_MODE, SERIRQ_OE, SERIRQ_O}), 32'h0);
    endtask
    task automatic test_continuous();
        IRQ_REQ = 32'h8001_0005;
        run_cycle(4'h4, 4'h3);
        check_frames(32'h8001_0005, 32);
        check(32'(QUIET_MODE), 32'h0);
        repeat (20)
        begin
            @(posedge REF_CLK);
            #1;
            check(32'(SERIRQ_OE), 32'h0);
        end
    endtask
    task automatic test_short_start();
        IRQ_REQ = 32'h0000_0002;
        run_cycle(4'h3, 4'h3);
        check_frames(32'h0, 32);
        check(32'(QUIET_MODE), 32'h0);
    endtask
    task automatic test_quiet();
        IRQ_REQ = 32'h0012_4002;
        run_cycle(4'h8, 4'h2);
        check(32'(QUIET_MODE), 32'h1);
        start_len = 4'h5;
        for (int i = 0; i < 8 && SERIRQ_OE !== 1'b1; i++)
        begin
            @(posedge REF_CLK);
            #1;
        end
        check(32'({SERIRQ_OE, SERIRQ_O}), 32'h2);
        @(posedge REF_CLK);
        #1;
        check(32'(SERIRQ_OE), 32'h0);
        wait_busy(1'b0);
        check_frames(32'h0012_4002, 32);
    endtask
    task automatic test_return();
        IRQ_REQ = 32'hffff_ffff;
        run_cycle(4'h4, 4'h3);
        check_frames(32'hffff_ffff, 32);
        check(32'(QUIET_MODE), 32'h0);
        IRQ_REQ = 32'h0;
        n_clk = 8'h68;
        run_cycle(4'h6, 4'h2);
        check_frames(32'h0, 32);
        check(32'(QUIET_MODE), 32'h1);
    endtask
    task automatic test_early_stop();
        start_len = 4'h4;
        stop_len = 4'h3;
        n_clk = 8'h41;
        IRQ_REQ = 32'h0010_0012;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check_frames(32'h0010_0012, 21);
        check(32'(QUIET_MODE), 32'h0);
        IRQ_REQ = 32'h0;
    endtask
    initial
    begin
        repeat (16) @(posedge REF_CLK);
        #1;
        RSTN = 1'b1;
        test_reset();
        test_continuous();
        test_short_start();
        test_quiet();
        test_return();
        test_early_stop();
        stop_test();
    end
endmodule
